// ==== hdl/tlop_pkg.sv ====
// Purpose: Shared constants and types for the transmit line output port.
// Assumes: 20 MHz ref_clk, APB register access, 32-bit data.
// Notes:   Line clock divider counts are derived from the nominal rates.
package tlop_pkg;

  // ----------------------------------------------------------------------
  // Clock and line rates
  // ----------------------------------------------------------------------
  localparam int REF_CLK_HZ  = 20_000_000;
  localparam int DS3_RATE_HZ = 44_736_000;
  localparam int E3_RATE_HZ  = 34_368_000;
  // Half period in ref_clk cycles, rounded down, never below one
  localparam int DS3_HALF_I  = REF_CLK_HZ / (2 * DS3_RATE_HZ);
  localparam int E3_HALF_I   = REF_CLK_HZ / (2 * E3_RATE_HZ);
  localparam logic [3:0] DS3_HALF_CYC = (DS3_HALF_I > 0) ?
                                        4'(DS3_HALF_I) : 4'h1;
  localparam logic [3:0] E3_HALF_CYC  = (E3_HALF_I > 0) ?
                                        4'(E3_HALF_I) : 4'h1;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] PORT_CTRL2_OFS  = 12'h000;
  localparam logic [11:0] PORT_STATUS_OFS = 12'h004;
  localparam logic [12:0] PORT_CTRL2_RST  = 13'h0000;
  localparam int CTL_W        = 13;
  localparam int PIN_EN_BIT   = 0;
  localparam int UNI_BIT      = 1;
  localparam int CODE_LO      = 2;
  localparam int SEL_LO       = 4;
  localparam int CLK_INV_BIT  = 7;
  localparam int DAT_INV_BIT  = 8;
  localparam int POS_DIS_BIT  = 9;
  localparam int LIU_EN_BIT   = 10;
  localparam int E3_BIT       = 11;
  localparam int REF_INV_BIT  = 12;

  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  localparam int EXT_CLKS = 4;
  typedef enum logic [1:0] {
    TLOP_AMI,
    TLOP_B3ZS,
    TLOP_HDB3
  } tlop_code_t;
  typedef enum logic [2:0] {
    TLOP_REF_LINE,
    TLOP_REF_TXO,
    TLOP_REF_TXI,
    TLOP_REF_RXL,
    TLOP_REF_RXO
  } tlop_ref_t;

endpackage

// ==== hdl/tlop_edge_sync.sv ====
// Purpose: Three-stage sampling and edge finding for outside clocks.
// Assumes: Inputs are asynchronous to ref_clk.
// Notes:   A change counts only once stages two and three agree.
`timescale 1ns/1ps
module tlop_edge_sync
  import tlop_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                rstn,
  input  wire logic [EXT_CLKS-1:0] async_in,
  output logic      [EXT_CLKS-1:0] level,
  output logic      [EXT_CLKS-1:0] rise,
  output logic      [EXT_CLKS-1:0] fall
);

  // ----------------------------------------------------------------------
  // Per-input synchroniser and filter
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < EXT_CLKS; i++) begin : g_sync
      logic s1_reg, s2_reg, s3_reg;
      logic lvl_reg, rise_reg, fall_reg;
      wire  agree = (s2_reg == s3_reg);
      wire  moved = agree && (s3_reg != lvl_reg);
      // Each input owns its own flops; the vectors are only gathered here
      assign level[i] = lvl_reg;
      assign rise[i]  = rise_reg;
      assign fall[i]  = fall_reg;
      // First stage feeds only the second, to contain metastability
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          s1_reg   <= 1'b0;
          s2_reg   <= 1'b0;
          s3_reg   <= 1'b0;
          lvl_reg  <= 1'b0;
          rise_reg <= 1'b0;
          fall_reg <= 1'b0;
        end else begin
          s1_reg   <= async_in[i];
          s2_reg   <= s1_reg;
          s3_reg   <= s2_reg;
          lvl_reg  <= moved ? s3_reg : lvl_reg;
          rise_reg <= moved & s3_reg;
          fall_reg <= moved & ~s3_reg;
        end
      end
    end
  endgenerate

endmodule

// ==== hdl/tlop_line_encoder.sv ====
// Purpose: AMI, B3ZS and HDB3 rail encoder with a four-bit delay line.
// Assumes: advance is a one-cycle pulse per line bit.
// Notes:   Latency is four bits in every mode, so switching mode keeps
//          the bit stream aligned.
`timescale 1ns/1ps
module tlop_line_encoder
  import tlop_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       advance,
  input  wire logic       bit_in,
  input  wire logic       bipolar,
  input  wire tlop_code_t code,
  output logic            pos_reg,
  output logic            neg_reg
);

  logic [3:0] mark_reg, viol_reg;
  logic       last_reg, odd_reg;

  // ----------------------------------------------------------------------
  // Exiting symbol and substitution decision
  // ----------------------------------------------------------------------
  // Violations repeat the last polarity, other marks alternate
  wire       ex_m  = mark_reg[3];
  wire       ex_v  = viol_reg[3];
  wire       pol   = ex_v ? last_reg : ~last_reg;
  wire       odd1  = ex_m ? (ex_v ? 1'b0 : ~odd_reg) : odd_reg;
  wire [3:0] nm    = {mark_reg[2:0], bit_in};
  wire [3:0] nv    = {viol_reg[2:0], 1'b0};
  // B3ZS window is three bits, so the oldest slot still counts
  wire       b3odd = nv[3] ? 1'b0 : (odd1 ^ nm[3]);
  wire       h_sub = bipolar && (code == TLOP_HDB3) && (nm == 4'h0);
  wire       b_sub = bipolar && (code == TLOP_B3ZS) && (nm[2:0] == 3'h0);
  wire       h_b   = h_sub & ~odd1;
  wire       b_b   = b_sub & ~b3odd;
  wire [3:0] mark_next = nm | {h_b, b_b, 1'b0, h_sub | b_sub};
  wire [3:0] viol_next = nv | {3'h0, h_sub | b_sub};

  // ----------------------------------------------------------------------
  // Delay line and rail outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mark_reg <= 4'h0;
      viol_reg <= 4'h0;
      last_reg <= 1'b0;
      odd_reg  <= 1'b0;
      pos_reg  <= 1'b0;
      neg_reg  <= 1'b0;
    end else if (advance) begin
      mark_reg <= mark_next;
      viol_reg <= viol_next;
      last_reg <= ex_m ? pol : last_reg;
      odd_reg  <= odd1;
      pos_reg  <= bipolar ? (ex_m & pol) : ex_m;
      neg_reg  <= bipolar & ex_m & ~pol;
    end
  end

endmodule

// ==== hdl/tlop_port.sv ====
// Purpose: Transmit line output port: line clock and rail pins.
// Assumes: ref_clk 20 MHz; outside clocks sampled, never used as clocks.
// Notes:   The line clock is divided from ref_clk, so its real rate is
//          capped at half of ref_clk.
//
// Behaviour
// - Line clock pin is driven only while the pin enable is set.
// - Line clock edges also time framer frame-start and serial signals.
// - Line clock at DS3 or E3 rate, one line bit per clock.
// - Coded modes drive the positive rail for positive pulses.
// - Unencoded mode puts the raw bit stream on the positive pin.
// - Rails update on rising edge, or falling edge if an outside reference is inverted.
// - Rail reference is selectable among five clocks, line clock default.
// - Positive rail may be disabled while the internal line unit is on.
// - Clock pin and data rails have independent polarity inversion.
// - Negative rail drives negative pulses, same edge and reference.
`timescale 1ns/1ps
module tlop_port
  import tlop_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        tx_clock_output,
  input  wire logic        tx_clock_input,
  input  wire logic        rx_line_clock_in,
  input  wire logic        rx_clock_output,
  input  wire logic        tx_bit_data,
  output logic             tx_bit_take,
  output logic             tx_line_tick,
  output logic             tx_line_clock_out,
  output logic             tx_line_clock_oe,
  output logic             tx_positive_rail,
  output logic             tx_positive_oe,
  output logic             tx_negative_rail,
  output logic             tx_negative_oe
);

  // ----------------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------------
  logic [CTL_W-1:0] ctrl_reg, ctrl_q;
  wire        en      = ctrl_reg[PIN_EN_BIT];
  wire        unencoded_data_mode     = ctrl_reg[UNI_BIT];
  wire [1:0]  code_f  = ctrl_reg[CODE_LO +: 2];
  wire [2:0]  sel     = ctrl_reg[SEL_LO +: 3];
  wire        clk_inv = ctrl_reg[CLK_INV_BIT];
  wire        dat_inv = ctrl_reg[DAT_INV_BIT];
  wire        pos_dis = ctrl_reg[POS_DIS_BIT];
  wire        liu_en  = ctrl_reg[LIU_EN_BIT];
  wire        e3      = ctrl_reg[E3_BIT];
  wire        ref_inv = ctrl_reg[REF_INV_BIT];
  // Reserved coding value falls back to plain AMI
  wire tlop_code_t code = (code_f == 2'h3) ? TLOP_AMI : tlop_code_t'(code_f);

  // ----------------------------------------------------------------------
  // Line clock divider
  // ----------------------------------------------------------------------
  logic [3:0] cnt_reg;
  logic       lclk_reg;
  wire  [3:0] half    = e3 ? E3_HALF_CYC : DS3_HALF_CYC;
  wire        cnt_hit = (cnt_reg == half - 4'h1);
  wire  [3:0] cnt_next = cnt_hit ? 4'h0 : cnt_reg + 4'h1;
  wire        lrise   = en & cnt_hit & ~lclk_reg;
  wire        lfall   = en & cnt_hit & lclk_reg;

  // Clock idles low while the pins are off
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg  <= 4'h0;
      lclk_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      lclk_reg <= en & (lclk_reg ^ cnt_hit);
    end
  end

  // ----------------------------------------------------------------------
  // Outside clock sampling
  // ----------------------------------------------------------------------
  logic [EXT_CLKS-1:0] ext_lvl, ext_rise, ext_fall;
  wire  [EXT_CLKS-1:0] ext_in = {rx_clock_output, rx_line_clock_in,
                                 tx_clock_input, tx_clock_output};

  tlop_edge_sync u_sync (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .async_in (ext_in),
    .level    (ext_lvl),
    .rise     (ext_rise),
    .fall     (ext_fall)
  );

  // ----------------------------------------------------------------------
  // Reference selection
  // ----------------------------------------------------------------------
  // Unused select codes fall back to the line clock
  function automatic logic pick_edge(input logic [2:0] s,
                                     input logic line_e,
                                     input logic [EXT_CLKS-1:0] ext_e);
    logic r;
    r = line_e;
    if (s >= 3'(TLOP_REF_TXO) && s <= 3'(TLOP_REF_RXO)) begin
      r = ext_e[2'(s - 3'h1)];
    end
    return r;
  endfunction

  wire sel_rise = pick_edge(sel, lrise, ext_rise);
  wire sel_fall = pick_edge(sel, lfall, ext_fall);
  wire line_ref = (sel == 3'(TLOP_REF_LINE)) || (sel > 3'(TLOP_REF_RXO));
  // A line reference never swaps edges: the pin inversion alone moves
  // the rail update onto the falling edge of the pin as seen outside
  wire inv_sel  = line_ref ? 1'b0 : ref_inv;
  // One bit leaves per chosen reference edge
  wire advance  = en & (inv_sel ? sel_fall : sel_rise);

  assign tx_bit_take = advance;

  // ----------------------------------------------------------------------
  // Encoder
  // ----------------------------------------------------------------------
  logic enc_pos, enc_neg;

  tlop_line_encoder u_enc (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .advance (advance),
    .bit_in  (tx_bit_data),
    .bipolar (~unencoded_data_mode),
    .code    (code),
    .pos_reg (enc_pos),
    .neg_reg (enc_neg)
  );

  // ----------------------------------------------------------------------
  // Pin stage
  // ----------------------------------------------------------------------
  logic clk_pin_reg, clk_oe_reg, pos_pin_reg, pos_oe_reg;
  logic neg_pin_reg, neg_oe_reg, tick_reg;

  // Everything held low and undriven while the pin enable is clear
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      clk_pin_reg <= 1'b0;
      clk_oe_reg  <= 1'b0;
      pos_pin_reg <= 1'b0;
      pos_oe_reg  <= 1'b0;
      neg_pin_reg <= 1'b0;
      neg_oe_reg  <= 1'b0;
      tick_reg    <= 1'b0;
    end else begin
      clk_pin_reg <= en & (lclk_reg ^ clk_inv);
      clk_oe_reg  <= en;
      pos_pin_reg <= en & (enc_pos ^ dat_inv);
      pos_oe_reg  <= en & ~(liu_en & pos_dis);
      neg_pin_reg <= en & ~unencoded_data_mode & (enc_neg ^ dat_inv);
      neg_oe_reg  <= en & ~unencoded_data_mode;
      tick_reg    <= lrise;
    end
  end

  assign tx_line_clock_out = clk_pin_reg;
  assign tx_line_clock_oe  = clk_oe_reg;
  assign tx_positive_rail  = pos_pin_reg;
  assign tx_positive_oe    = pos_oe_reg;
  assign tx_negative_rail  = neg_pin_reg;
  assign tx_negative_oe    = neg_oe_reg;
  assign tx_line_tick      = tick_reg;

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  // Zero wait states: the read word is captured in the setup cycle
  wire        hit_ctl = (paddr == PORT_CTRL2_OFS);
  wire        hit_sts = (paddr == PORT_STATUS_OFS);
  wire        wr_ctl  = psel & penable & pwrite & hit_ctl;
  wire        rd_set  = psel & ~penable & ~pwrite;
  wire [31:0] sts_w   = {24'h0, ext_lvl, lclk_reg, enc_neg, enc_pos, en};
  wire [31:0] rd_mux  = hit_ctl ? {19'h0, ctrl_reg} :
                        hit_sts ? sts_w : 32'h0;
  logic [31:0] prdata_reg;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~(hit_ctl | hit_sts);
  assign prdata  = prdata_reg;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg   <= PORT_CTRL2_RST;
      ctrl_q     <= PORT_CTRL2_RST;
      prdata_reg <= 32'h0;
    end else begin
      ctrl_reg   <= wr_ctl ? pwdata[CTL_W-1:0] : ctrl_reg;
      ctrl_q     <= ctrl_reg;
      prdata_reg <= rd_set ? rd_mux : prdata_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  wire steady = (ctrl_reg == ctrl_q);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  clk_gated_a: assert property (
    !en |=> !tx_line_clock_out && !tx_line_clock_oe
  ) else $error("line clock active while pins disabled");

  idle_low_a: assert property (
    !en && $past(!en) |-> !tx_positive_rail && !tx_negative_rail
  ) else $error("rails not idle while pins disabled");

  line_rate_a: assert property (
    $rose(lclk_reg) && $past(en) |-> $past(lrise)
  ) else $error("line clock rose without divider terminal count");

  tick_align_a: assert property (
    tx_line_tick |-> lclk_reg && $past(en)
  ) else $error("line tick not aligned to line clock rise");

  edge_pick_a: assert property (
    tx_bit_take && line_ref |-> lrise
  ) else $error("bit taken off the rising line clock edge");

  rail_cause_a: assert property (
    $changed(tx_positive_rail) && steady && $past(steady)
      |-> $past(tx_bit_take, 2)
  ) else $error("positive rail moved without a reference edge");

  liu_off_a: assert property (
    en && liu_en && pos_dis |=> !tx_positive_oe
  ) else $error("positive rail driven with line unit on");

  uni_neg_a: assert property (
    tx_bit_take && unencoded_data_mode && steady |=> ##1 (!tx_negative_rail || !steady)
  ) else $error("negative rail active in unencoded mode");

  rail_excl_a: assert property (
    !unencoded_data_mode && !dat_inv && steady && $past(steady)
      |-> !(tx_positive_rail && tx_negative_rail)
  ) else $error("both rails high at once");

  clk_inv_a: assert property (
    en && steady && $past(steady)
      |-> tx_line_clock_out == ($past(lclk_reg) ^ clk_inv)
  ) else $error("line clock pin polarity wrong");

  // Enables follow the control word one cycle later
  clk_oe_a: assert property (
    tx_line_clock_oe == $past(en)
  ) else $error("line clock enable does not follow pin enable");

  pos_oe_a: assert property (
    tx_positive_oe == $past(en && !(liu_en && pos_dis))
  ) else $error("positive rail enable wrong");

  neg_oe_a: assert property (
    tx_negative_oe == $past(en && !unencoded_data_mode)
  ) else $error("negative rail enable wrong");

  // Nothing is consumed while disabled and the clock cannot rise twice in a row
  take_gate_a: assert property (
    !en |-> !tx_bit_take
  ) else $error("bit taken while pins disabled");

  tick_gap_a: assert property (
    tx_line_tick |=> !tx_line_tick
  ) else $error("line clock rose on two cycles in a row");

  tick_take_a: assert property (
    tx_bit_take && line_ref |=> tx_line_tick
  ) else $error("line tick missing after a line clock bit");

  // Rails carry the encoder output, with the shared inversion
  pos_data_a: assert property (
    en && steady && $past(steady)
      |-> tx_positive_rail == ($past(enc_pos) ^ dat_inv)
  ) else $error("positive rail does not carry encoder output");

  neg_data_a: assert property (
    en && !unencoded_data_mode && steady && $past(steady)
      |-> tx_negative_rail == ($past(enc_neg) ^ dat_inv)
  ) else $error("negative rail does not carry encoder output");

  // Against the pin itself: rising when plain, falling when inverted
  rail_edge_a: assert property (
    $changed(tx_positive_rail) && line_ref && en && steady && $past(steady)
      |-> $changed(tx_line_clock_out) && tx_line_clock_out == !clk_inv
  ) else $error("positive rail moved off the selected line clock edge");

  // A completed write must land in the control word
  ctl_write_a: assert property (
    wr_ctl |=> ctrl_reg == $past(pwdata[CTL_W-1:0])
  ) else $error("control write did not land");

endmodule

// ==== verification/tlop_liu_model.sv ====
// Purpose: Far-side line unit model, counts line clock edges and marks.
// Assumes: Pins sampled on ref_clk; rails change at most once a cycle.
// Notes:   Counters only grow between resets; the bench works on differences.
`timescale 1ns/1ps
module tlop_liu_model (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic line_clk,
  input  wire logic line_clk_oe,
  input  wire logic pos,
  input  wire logic pos_oe,
  input  wire logic neg,
  input  wire logic neg_oe,
  output int        n_clk,
  output int        n_pos,
  output int        n_neg,
  output int        n_both
);
  logic clk_q;
  logic pos_q;
  logic neg_q;

  // ----------------------------------------------------------------------
  // Edge counting
  // ----------------------------------------------------------------------
  // Rising edges count marks; an undriven rail never counts
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      {clk_q, pos_q, neg_q} <= 3'h0;
      {n_clk, n_pos, n_neg, n_both} <= '0;
    end else begin
      clk_q <= line_clk;
      pos_q <= pos;
      neg_q <= neg;
      if (line_clk_oe === 1'b1 && line_clk === 1'b1 && clk_q === 1'b0)
        n_clk <= n_clk + 1;
      if (pos_oe === 1'b1 && pos === 1'b1 && pos_q === 1'b0)
        n_pos <= n_pos + 1;
      if (neg_oe === 1'b1 && neg === 1'b1 && neg_q === 1'b0)
        n_neg <= n_neg + 1;
      // Both rails marked at once is never a legal line symbol
      if (pos_oe === 1'b1 && neg_oe === 1'b1 && pos === 1'b1 && neg === 1'b1)
        n_both <= n_both + 1;
    end
  end
endmodule

// ==== verification/tb_top.sv ====
// Purpose: Self-checking bench for the transmit line output port.
// Assumes: 50 ns ref_clk, outside clocks of 400 ns at odd phases.
// Notes:   Mark counts are checked in ranges, edges sit off the grid.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin \
  n_fail++; $display("BAD %s exp %0h got %0h", nm, ex, gt); end end
module tb_top
  import tlop_pkg::*;
();
  logic        ref_clk = 0;
  logic        rstn    = 0;
  logic        psel    = 0;
  logic        penable = 0;
  logic        pwrite  = 0;
  logic [11:0] paddr   = '0;
  logic [31:0] pwdata  = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  ext     = '0;
  logic        tx_bit_data = 0;
  logic        take, tick, lclk, lclk_oe, pos, pos_oe, neg, neg_oe;
  int          n_fail, checks_done, n_clk, n_pos, n_neg, n_both;
  int          tk, tc, c0, p0, m0, b0, d;
  logic [31:0] q;
  logic        e;

  // ----------------------------------------------------------------------
  // Clocks and instances
  // ----------------------------------------------------------------------
  always #25 ref_clk = ~ref_clk;
  initial begin #13;  forever #200 ext[0] = ~ext[0]; end
  initial begin #61;  forever #200 ext[1] = ~ext[1]; end
  initial begin #113; forever #200 ext[2] = ~ext[2]; end
  initial begin #167; forever #200 ext[3] = ~ext[3]; end

  tlop_port dut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_clock_output(ext[0]), .tx_clock_input(ext[1]),
    .rx_line_clock_in(ext[2]), .rx_clock_output(ext[3]),
    .tx_bit_data(tx_bit_data), .tx_bit_take(take), .tx_line_tick(tick),
    .tx_line_clock_out(lclk), .tx_line_clock_oe(lclk_oe),
    .tx_positive_rail(pos), .tx_positive_oe(pos_oe),
    .tx_negative_rail(neg), .tx_negative_oe(neg_oe));

  tlop_liu_model liu (.ref_clk(ref_clk), .rstn(rstn), .line_clk(lclk),
    .line_clk_oe(lclk_oe), .pos(pos), .pos_oe(pos_oe), .neg(neg),
    .neg_oe(neg_oe), .n_clk(n_clk), .n_pos(n_pos), .n_neg(n_neg),
    .n_both(n_both));

  // ----------------------------------------------------------------------
  // Access and measuring tasks
  // ----------------------------------------------------------------------
  // One APB transfer; waits for pready, never a fixed count
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge ref_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1;
    n = 0;
    do begin @(posedge ref_clk); n++; end while (pready !== 1'b1 && n < 50);
    `CHK("pready", 1'b1, pready)
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask

  task automatic run(input int n);
    c0 = n_clk; p0 = n_pos; m0 = n_neg; b0 = n_both; tk = 0; tc = 0;
    repeat (n) begin
      @(posedge ref_clk);
      if (take === 1'b1) tk++;
      if (tick === 1'b1) tc++;
    end
  endtask

  // Skips two cycles so a take left from the previous edge is not seen
  task automatic delay_after(input int i);
    @(posedge ext[i]);
    repeat (2) @(posedge ref_clk);
    d = 2;
    while (take !== 1'b1 && d < 20) begin @(posedge ref_clk); d++; end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog, far beyond the fewer than two thousand cycles the tests need
  initial begin
    #1_000_000;
    n_fail++;
    summarize();
  end

  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk);
    rstn <= 1;
    `CHK("clk_oe", 1'b0, lclk_oe)
    `CHK("pos", 1'b0, pos)
    apb(0, PORT_CTRL2_OFS, 0);
    `CHK("ctl_rst", 32'(PORT_CTRL2_RST), q)
    apb(0, 12'h008, 0);
    `CHK("unmapped", 33'h1_0000_0000, {e, q})
    apb(1, PORT_CTRL2_OFS, 32'hffff_fffe);
    apb(1, PORT_STATUS_OFS, 32'hffff_ffff);
    apb(0, PORT_CTRL2_OFS, 0);
    `CHK("ctl_rw", 32'h0000_1ffe, q)
    // Disabled pins: nothing taken, nothing toggles
    tx_bit_data <= 1;
    run(40);
    `CHK("dis_take", 0, tk)
    `CHK("dis_clk", 0, n_clk - c0)
    `CHK("dis_oe", 4'h0, {lclk_oe, pos_oe, neg_oe, pos})
    // AMI with all ones, line clock reference
    apb(1, PORT_CTRL2_OFS, 32'h1);
    run(20);
    run(40);
    `CHK("take_rate", 1'b1, tk >= 19 && tk <= 21)
    `CHK("tick_take", tk, tc)
    `CHK("clk_rate", 1'b1, n_clk - c0 >= 19 && n_clk - c0 <= 21)
    `CHK("pos_marks", 1'b1, n_pos - p0 >= 9 && n_pos - p0 <= 11)
    `CHK("neg_marks", 1'b1, n_neg - m0 >= 9 && n_neg - m0 <= 11)
    `CHK("both", 0, n_both - b0)
    // Plain pin is low in the cycle after the internal clock rose
    do @(posedge ref_clk); while (tick !== 1'b1);
    `CHK("clk_pol", 1'b0, lclk)
    apb(0, PORT_STATUS_OFS, 0);
    `CHK("sts_en", 1'b1, q[0])
    // Inverted line clock pin at the E3 setting
    apb(1, PORT_CTRL2_OFS, 32'(1 | (1 << CLK_INV_BIT) | (1 << E3_BIT)));
    run(20);
    run(40);
    `CHK("e3_rate", 1'b1, tk >= 19 && tk <= 21)
    `CHK("inv_clk", 1'b1, n_clk - c0 >= 19 && n_clk - c0 <= 21)
    do @(posedge ref_clk); while (tick !== 1'b1);
    `CHK("inv_pol", 1'b1, lclk)
    // All zeros: only the substituting codes make marks
    tx_bit_data <= 0;
    for (int c = 0; c < 4; c++) begin
      apb(1, PORT_CTRL2_OFS, 32'(1 | (c << CODE_LO)));
      run(20);
      run(60);
      `CHK("zero_marks", c == 1 || c == 2, n_pos - p0 + n_neg - m0 > 0)
    end
    // Unencoded data on the positive pin, negative pin released
    tx_bit_data <= 1;
    apb(1, PORT_CTRL2_OFS, 32'h3);
    run(24);
    `CHK("uni_one", 3'h6, {pos, pos_oe, neg_oe})
    tx_bit_data <= 0;
    run(24);
    `CHK("uni_zero", 1'b0, pos)
    apb(1, PORT_CTRL2_OFS, 32'(3 | (1 << DAT_INV_BIT)));
    run(24);
    `CHK("uni_inv", 1'b1, pos)
    // Positive rail disable needs the internal line unit on
    apb(1, PORT_CTRL2_OFS, 32'(1 | (3 << POS_DIS_BIT)));
    run(4);
    `CHK("pos_dis", 2'h1, {pos_oe, lclk_oe})
    apb(1, PORT_CTRL2_OFS, 32'(1 | (1 << POS_DIS_BIT)));
    run(4);
    `CHK("pos_kept", 1'b1, pos_oe)
    // Outside references, both edges
    for (int s = 1; s < 5; s++) begin
      for (int v = 0; v < 2; v++) begin
        apb(1, PORT_CTRL2_OFS, 32'(1 | (s << SEL_LO) | (v << REF_INV_BIT)));
        run(80);
        `CHK("ref_rate", 1'b1, tk >= 9 && tk <= 11)
        delay_after(s - 1);
        `CHK("ref_edge", 1'b1, v ? (d >= 6 && d <= 9) : (d <= 5))
      end
    end
    // Reset in mid-run: pins released, control back to its reset value
    rstn <= 0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1;
    run(4);
    `CHK("rst_oe", 3'h0, {lclk_oe, pos_oe, neg_oe})
    apb(0, PORT_CTRL2_OFS, 0);
    `CHK("rst_ctl", 32'(PORT_CTRL2_RST), q)
    summarize();
  end
endmodule
